// ==== stpc_consts.svh ====
`ifndef STPC_CONSTS_SVH
`define STPC_CONSTS_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define STPC_ADDR_W 3
`define STPC_DATA_W 16
`define STPC_ADDR_CTRL 3'h0
`define STPC_ADDR_CONFIG 3'h1
`define STPC_ADDR_COUNT 3'h2
`define STPC_ADDR_CMPA 3'h3
`define STPC_ADDR_CMPP 3'h4

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define STPC_CTRL_RUN_BIT 0
`define STPC_CFG_MODE_LO 0
`define STPC_CFG_MODE_HI 1
`define STPC_CFG_PIN_LO 2
`define STPC_CFG_PIN_HI 3
`define STPC_CFG_OC_BIT 4
`define STPC_CFG_POL_BIT 5
`define STPC_CFG_CCLR_BIT 6
`define STPC_CFG_DPX_BIT 7

// ----------------------------------------------------------------------
// Codes, reset values and counter limits
// ----------------------------------------------------------------------
`define STPC_MODE_COMPARE 2'h0
`define STPC_MODE_CAPTURE 2'h1
`define STPC_MODE_PULSE 2'h2
`define STPC_MODE_TIMER 2'h3
`define STPC_PIN_RISE 2'h0
`define STPC_PIN_FALL 2'h1
`define STPC_PIN_BOTH 2'h2
`define STPC_PIN_SINGLE 2'h3
`define STPC_CNT_W 10
`define STPC_CNT_MAX 10'h3ff
`define STPC_CFG_RESET 8'h00
`define STPC_CMP_RESET 10'h000

`endif

// ==== stpc_counter.sv ====
`timescale 1ns/1ps

module stpc_counter #(
  parameter int CNT_W = 10
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Control
  input wire logic clr_i,
  input wire logic inc_i,
  // Count
  output logic [CNT_W-1:0] cnt_o
);

  logic [CNT_W-1:0] cnt_ff;

  // Clear wins over increment; the count wraps at its maximum.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_ff <= '0;
    end else if (clr_i) begin
      cnt_ff <= '0;
    end else if (inc_i) begin
      cnt_ff <= cnt_ff + 1'b1;
    end
  end

  assign cnt_o = cnt_ff;

endmodule : stpc_counter

// ==== stpc_pin_model.sv ====
`timescale 1ns/1ps

// ----------------------------------------------------------------------
// External trigger and capture sources
// ----------------------------------------------------------------------
module stpc_pin_model (
  // Clock
  input wire logic clk_i,
  // Requests from the bench
  input wire logic trig_req_i,
  input wire logic cap_req_i,
  // Pins
  output logic external_trigger_pin_o = 1'b0,
  output logic capture_input_pin_o = 1'b0
);
  // Pins move just after a rising edge of the clock the timer samples them on.
  always @(posedge clk_i) begin
    external_trigger_pin_o <= trig_req_i;
    capture_input_pin_o <= cap_req_i;
  end
endmodule : stpc_pin_model

// ==== stpc_pkg.sv ====
`include "stpc_consts.svh"

package stpc_pkg;

  typedef enum logic [1:0] {
    STPC_COMPARE = `STPC_MODE_COMPARE,
    STPC_CAPTURE = `STPC_MODE_CAPTURE,
    STPC_PULSE = `STPC_MODE_PULSE,
    STPC_TIMER = `STPC_MODE_TIMER
  } stpc_mode_t;

  typedef logic [`STPC_CNT_W-1:0] stpc_count_t;

endpackage : stpc_pkg

// ==== stpc_sync_edge.sv ====
`timescale 1ns/1ps

module stpc_sync_edge (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Pin and edge pulses
  input wire logic pin_i,
  output logic rise_o,
  output logic fall_o
);

  logic meta_ff;
  logic sync_ff;
  logic last_ff;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_ff <= 1'b0;
      sync_ff <= 1'b0;
      last_ff <= 1'b0;
    end else begin
      meta_ff <= pin_i;
      sync_ff <= meta_ff;
      last_ff <= sync_ff;
    end
  end

  assign rise_o = sync_ff & ~last_ff;
  assign fall_o = ~sync_ff & last_ff;

endmodule : stpc_sync_edge

// ==== stpc_timer.sv ====
// Functional notes
// - A rising run-enable starts the pulse leading edge.
// - Trigger pin rising edge sets run-enable in single pulse mode.
// - Counter start and leading edge happen on the same edge.
// - Software clearing run-enable makes the trailing edge.
// - Compare A match clears run-enable and ends the pulse.
// - Compare A match in single pulse raises the A interrupt.
// - Counter clears when run-enable rises and on a compare P match in capture mode.
// - Single pulse ignores compare P, clear select and swap bits.
// - Capture mode counter starts on run-enable rise.
// - Selected capture edge copies count to compare A, interrupts.
// - Capture mode counter runs freely until run-enable falls.
// - Compare P match clears counter and raises an interrupt.
// - Compare P of zero lets counter wrap at its maximum.
// - Pin function 11 disables capture; counter keeps running.
// - Capture mode drives no output and ignores output bits.
// - Counter is 10 bits and wraps at 3ff.
//
// Our own choices: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
`include "stpc_consts.svh"

module stpc_timer
  import stpc_pkg::*;
#(
  parameter int CNT_W = `STPC_CNT_W
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Register port
  input wire logic [`STPC_ADDR_W-1:0] addr_i,
  input wire logic [`STPC_DATA_W-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [`STPC_DATA_W-1:0] rdata_o,
  // Pins
  input wire logic external_trigger_pin_i,
  input wire logic capture_input_pin_i,
  output logic timer_out_o,
  output logic timer_out_en_o,
  // Events
  output logic irq_a_o,
  output logic irq_p_o,
  output logic counter_run_enable_o
);

  // --------------------------------------------------------------------
  // Elaboration check
  // --------------------------------------------------------------------
  generate
    if (CNT_W != `STPC_CNT_W) begin : g_bad_width
      $error("stpc_timer supports only the documented counter width");
    end
  endgenerate

  // --------------------------------------------------------------------
  // Declarations
  // --------------------------------------------------------------------
  logic counter_run_enable_ff;
  logic nxt_counter_run_enable;
  logic [7:0] timer_control_second_ff;
  stpc_count_t compare_a_value_ff;
  stpc_count_t compare_p_value_ff;
  logic [`STPC_DATA_W-1:0] rdata_ff;
  logic timer_out_ff;
  logic timer_out_en_ff;
  logic irq_a_ff;
  logic irq_p_ff;
  stpc_count_t cnt;
  logic trig_rise;
  logic cap_rise;
  logic cap_fall;
  stpc_mode_t op_mode;
  logic [1:0] pin_function;
  logic output_initial_level;
  logic output_invert;
  logic pulse_mode;
  logic cap_mode;
  logic start;
  logic sw_run_we;
  logic a_match_sp;
  logic p_match;
  logic cap_take;
  logic cnt_clr;
  logic cnt_inc;

  // --------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------
  function automatic logic is_wr(input logic [`STPC_ADDR_W-1:0] a);
    is_wr = wr_i && (addr_i == a);
  endfunction : is_wr

  function automatic logic edge_hit(input logic [1:0] sel,
                                    input logic rise,
                                    input logic fall);
    case (sel)
      `STPC_PIN_RISE: edge_hit = rise;
      `STPC_PIN_FALL: edge_hit = fall;
      `STPC_PIN_BOTH: edge_hit = rise | fall;
      default: edge_hit = 1'b0;
    endcase
  endfunction : edge_hit

  // --------------------------------------------------------------------
  // Pin synchronisers and counter
  // --------------------------------------------------------------------
  stpc_sync_edge u_trig_sync (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .pin_i(external_trigger_pin_i),
    .rise_o(trig_rise),
    .fall_o()
  );

  stpc_sync_edge u_cap_sync (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .pin_i(capture_input_pin_i),
    .rise_o(cap_rise),
    .fall_o(cap_fall)
  );

  stpc_counter #(
    .CNT_W(CNT_W)
  ) u_counter (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .clr_i(cnt_clr),
    .inc_i(cnt_inc),
    .cnt_o(cnt)
  );

  // --------------------------------------------------------------------
  // Mode decode and events
  // --------------------------------------------------------------------
  assign op_mode = stpc_mode_t'(timer_control_second_ff[
      `STPC_CFG_MODE_HI:`STPC_CFG_MODE_LO]);
  assign pin_function = timer_control_second_ff[
      `STPC_CFG_PIN_HI:`STPC_CFG_PIN_LO];
  assign output_initial_level = timer_control_second_ff[`STPC_CFG_OC_BIT];
  assign output_invert = timer_control_second_ff[`STPC_CFG_POL_BIT];
  assign pulse_mode = (op_mode == STPC_PULSE) &&
                      (pin_function == `STPC_PIN_SINGLE);
  assign cap_mode = (op_mode == STPC_CAPTURE);
  assign sw_run_we = wr_i && (addr_i == `STPC_ADDR_CTRL);
  assign start = nxt_counter_run_enable & ~counter_run_enable_ff;
  // Compare P, clear select and swap are not looked at here.
  assign a_match_sp = pulse_mode && counter_run_enable_ff &&
                      (cnt == compare_a_value_ff);
  // A zero compare P lets the count wrap; the wrap counts as the match.
  assign p_match = (compare_p_value_ff == `STPC_CMP_RESET) ?
                   (cnt == `STPC_CNT_MAX) :
                   (cnt == compare_p_value_ff);
  assign cap_take = cap_mode &&
                    edge_hit(pin_function, cap_rise, cap_fall);
  assign cnt_clr = start ||
                   (cap_mode && counter_run_enable_ff && p_match);
  assign cnt_inc = counter_run_enable_ff;

  // --------------------------------------------------------------------
  // Run enable
  // --------------------------------------------------------------------
  always_comb begin
    if (sw_run_we) begin
      nxt_counter_run_enable = wdata_i[`STPC_CTRL_RUN_BIT];
    end else if (pulse_mode && trig_rise) begin
      nxt_counter_run_enable = 1'b1;
    end else if (a_match_sp) begin
      nxt_counter_run_enable = 1'b0;
    end else begin
      nxt_counter_run_enable = counter_run_enable_ff;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      counter_run_enable_ff <= 1'b0;
    end else begin
      counter_run_enable_ff <= nxt_counter_run_enable;
    end
  end

  // --------------------------------------------------------------------
  // Configuration and compare registers
  // --------------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      timer_control_second_ff <= `STPC_CFG_RESET;
    end else if (is_wr(`STPC_ADDR_CONFIG)) begin
      timer_control_second_ff <= wdata_i[7:0];
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      compare_a_value_ff <= `STPC_CMP_RESET;
    end else if (cap_take) begin
      compare_a_value_ff <= cnt;
    end else if (is_wr(`STPC_ADDR_CMPA)) begin
      compare_a_value_ff <= wdata_i[CNT_W-1:0];
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      compare_p_value_ff <= `STPC_CMP_RESET;
    end else if (is_wr(`STPC_ADDR_CMPP)) begin
      compare_p_value_ff <= wdata_i[CNT_W-1:0];
    end
  end

  // --------------------------------------------------------------------
  // Timer output and interrupt pulses
  // --------------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      timer_out_ff <= 1'b0;
      timer_out_en_ff <= 1'b0;
    end else if (pulse_mode) begin
      timer_out_ff <= (nxt_counter_run_enable ? output_initial_level :
                       ~output_initial_level) ^ output_invert;
      timer_out_en_ff <= 1'b1;
    end else begin
      timer_out_ff <= 1'b0;
      timer_out_en_ff <= 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      irq_a_ff <= 1'b0;
      irq_p_ff <= 1'b0;
    end else begin
      irq_a_ff <= a_match_sp || cap_take;
      irq_p_ff <= cap_mode && counter_run_enable_ff && p_match;
    end
  end

  // --------------------------------------------------------------------
  // Read port
  // --------------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_ff <= '0;
    end else if (rd_i) begin
      case (addr_i)
        `STPC_ADDR_CTRL:
          rdata_ff <= {15'h0000, counter_run_enable_ff};
        `STPC_ADDR_CONFIG:
          rdata_ff <= {8'h00, timer_control_second_ff};
        `STPC_ADDR_COUNT:
          rdata_ff <= {6'h00, cnt};
        `STPC_ADDR_CMPA:
          rdata_ff <= {6'h00, compare_a_value_ff};
        `STPC_ADDR_CMPP:
          rdata_ff <= {6'h00, compare_p_value_ff};
        default:
          rdata_ff <= '0;
      endcase
    end else begin
      rdata_ff <= '0;
    end
  end

  assign rdata_o = rdata_ff;
  assign timer_out_o = timer_out_ff;
  assign timer_out_en_o = timer_out_en_ff;
  assign irq_a_o = irq_a_ff;
  assign irq_p_o = irq_p_ff;
  assign counter_run_enable_o = counter_run_enable_ff;

  // --------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------
  a_start_clears_cnt: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    $rose(counter_run_enable_ff) |-> (cnt == '0))
    else $error("counter not zero after run enable rose");
  a_lead_edge_level: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    (pulse_mode && start && !(wr_i && addr_i == `STPC_ADDR_CONFIG)) |=>
      (timer_out_o == (output_initial_level ^ output_invert)) &&
      counter_run_enable_o)
    else $error("leading edge not with counter start");
  a_match_ends_run: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    (a_match_sp && !sw_run_we && !trig_rise) |=>
      !counter_run_enable_ff ##1 !counter_run_enable_ff || $past(trig_rise) ||
      $past(sw_run_we))
    else $error("compare A match did not end the pulse");
  a_match_irq: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    a_match_sp |=> irq_a_o ##1 (!irq_a_o || $past(a_match_sp || cap_take)))
    else $error("compare A match raised no interrupt");
  a_trig_start: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    (pulse_mode && trig_rise && !counter_run_enable_ff && !sw_run_we) |=>
      counter_run_enable_ff && (cnt == '0))
    else $error("trigger pin did not start the pulse");
  a_sw_trail_edge: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    (pulse_mode && sw_run_we && !wdata_i[`STPC_CTRL_RUN_BIT] &&
     !(wr_i && addr_i == `STPC_ADDR_CONFIG)) |=>
      (timer_out_o == (~output_initial_level ^ output_invert)))
    else $error("software clear did not end the pulse");
  a_cap_latch: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    cap_take |=> (compare_a_value_ff == $past(cnt)) && irq_a_o)
    else $error("capture did not latch the count");
  a_cap_disabled: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    (cap_mode && pin_function == `STPC_PIN_SINGLE &&
     !(wr_i && addr_i == `STPC_ADDR_CMPA) && counter_run_enable_ff &&
     !p_match && !sw_run_we) |=>
      $stable(compare_a_value_ff) && (cnt == $past(cnt) + 1'b1))
    else $error("capture happened while disabled");
  a_p_match_wrap: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    (cap_mode && counter_run_enable_ff && p_match && !sw_run_we) |=>
      (cnt == '0) && irq_p_o)
    else $error("compare P match did not wrap the counter");
  a_cap_no_output: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    cap_mode |=> !timer_out_en_o && !timer_out_o)
    else $error("capture mode drove the output");

endmodule : stpc_timer

// ==== timer_single_pulse_capture_test.sv ====
`timescale 1ns/1ps
`include "stpc_consts.svh"

module timer_single_pulse_capture_test
  import stpc_pkg::*;
;
  // ----------------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------------
  typedef struct {
    logic [7:0] cfg;
    logic [9:0] cmpa;
    logic act;
    int width;
  } stpc_row_t;
  stpc_row_t rows [4] = '{'{8'h1e, 10'h002, 1'b1, 3},
    '{8'h0e, 10'h000, 1'b0, 1}, '{8'hfe, 10'h005, 1'b0, 6},
    '{8'hde, 10'h007, 1'b1, 8}};
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [2:0] addr_i = 3'h0;
  logic [15:0] wdata_i = 16'h0000;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic trig_req = 1'b0;
  logic cap_req = 1'b0;
  logic [15:0] rdata_o;
  logic ext_pin;
  logic cap_pin;
  logic timer_out_o;
  logic timer_out_en_o;
  logic irq_a_o;
  logic irq_p_o;
  logic counter_run_enable_o;
  int fail_count = 0;
  int tests_run = 0;

  always #50 clk_i = ~clk_i;

  stpc_timer dut_u (.clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .external_trigger_pin_i(ext_pin), .capture_input_pin_i(cap_pin),
    .timer_out_o(timer_out_o), .timer_out_en_o(timer_out_en_o),
    .irq_a_o(irq_a_o), .irq_p_o(irq_p_o),
    .counter_run_enable_o(counter_run_enable_o));

  stpc_pin_model pin_u (.clk_i(clk_i), .trig_req_i(trig_req),
    .cap_req_i(cap_req), .external_trigger_pin_o(ext_pin),
    .capture_input_pin_o(cap_pin));

  // ----------------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------------
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    @(posedge clk_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask : wr

  task automatic rd(input logic [2:0] a, output logic [15:0] d);
    @(posedge clk_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1;
    d = rdata_o;
  endtask : rd

  task automatic wait_sig(input int sel, input int lim, output int k);
    logic s;
    k = 0;
    s = 1'b0;
    while (s !== 1'b1 && k < lim) begin
      @(posedge clk_i);
      #1;
      k++;
      s = sel == 0 ? irq_a_o : sel == 1 ? irq_p_o :
        sel == 2 ? ~counter_run_enable_o : counter_run_enable_o;
    end
  endtask : wait_sig

  task automatic tally_and_finish();
    $display("Comparisons %0d, mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : tally_and_finish

  initial begin
    #5000000;
    fail_count++;
    tally_and_finish();
  end

  // ----------------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------------
  initial begin
    logic [15:0] d;
    logic [15:0] exp_a;
    logic act;
    logic hit;
    int k;
    int p;
    repeat (16) @(posedge clk_i);
    check({irq_a_o, irq_p_o, timer_out_o}, '0);
    check({counter_run_enable_o, timer_out_en_o}, '0);
    rst_n_i <= 1'b1;
    for (int a = 0; a < 6; a++) begin
      rd(a[2:0], d);
      check(d, 16'h0000);
    end
    exp_a = 16'h0000;
    for (int i = 0; i < 8; i++) begin
      p = i / 2;
      hit = (i % 2 == 0) ? (p == 0 || p == 2) : (p == 1 || p == 2);
      wr(`STPC_ADDR_CTRL, 16'h0000);
      wr(`STPC_ADDR_CONFIG, 16'h0031 | 16'(p << 2));
      wr(`STPC_ADDR_CTRL, 16'h0001);
      cap_req <= ~cap_req;
      wait_sig(0, 12, k);
      check(irq_a_o, hit);
      check({timer_out_o, timer_out_en_o}, 0);
      if (hit) begin
        exp_a = 16'(k - 1);
      end
      rd(`STPC_ADDR_COUNT, d);
      check(d, 16'(k + 1));
      rd(`STPC_ADDR_CMPA, d);
      check(d, exp_a);
    end
    wr(`STPC_ADDR_CTRL, 16'h0000);
    wr(`STPC_ADDR_CMPP, 16'h0005);
    wr(`STPC_ADDR_CTRL, 16'h0001);
    wait_sig(1, 20, k);
    check(16'(k), 16'd6);
    wr(`STPC_ADDR_CTRL, 16'h0000);
    wr(`STPC_ADDR_CMPP, 16'h0000);
    wr(`STPC_ADDR_CTRL, 16'h0001);
    wait_sig(1, 1100, k);
    check(16'(k), 16'd1024);
    wr(`STPC_ADDR_CTRL, 16'h0000);
    wr(`STPC_ADDR_CMPP, 16'h0001);
    foreach (rows[r]) begin
      act = rows[r].act;
      wr(`STPC_ADDR_CONFIG, {8'h00, rows[r].cfg});
      wr(`STPC_ADDR_CMPA, {6'h00, rows[r].cmpa});
      #1;
      check({timer_out_o}, {~act});
      wr(`STPC_ADDR_CTRL, 16'h0001);
      #1;
      check({counter_run_enable_o, timer_out_o}, {1'b1, act});
      check({timer_out_en_o}, 16'h0001);
      wait_sig(2, 20, k);
      check(16'(k), 16'(rows[r].width));
      check({timer_out_o, irq_a_o}, {~act, 1'b1});
      @(posedge clk_i);
      #1;
      check(irq_a_o, 1'b0);
    end
    wr(`STPC_ADDR_CONFIG, 16'h001e);
    wr(`STPC_ADDR_CMPA, 16'h0032);
    wr(`STPC_ADDR_CTRL, 16'h0001);
    repeat (3) @(posedge clk_i);
    wr(`STPC_ADDR_CTRL, 16'h0000);
    #1;
    check({counter_run_enable_o, timer_out_o, irq_a_o}, 0);
    wr(`STPC_ADDR_CMPA, 16'h0003);
    trig_req <= 1'b1;
    wait_sig(3, 8, k);
    check({counter_run_enable_o, timer_out_o}, 2'h3);
    trig_req <= 1'b0;
    wait_sig(2, 20, k);
    check(16'(k), 16'd4);
    wr(`STPC_ADDR_CTRL, 16'h0001);
    @(posedge clk_i);
    rst_n_i <= 1'b0;
    #1;
    check({counter_run_enable_o, timer_out_o, timer_out_en_o}, 0);
    @(posedge clk_i);
    rst_n_i <= 1'b1;
    rd(`STPC_ADDR_CONFIG, d);
    check(d, 16'h0000);
    wr(`STPC_ADDR_CONFIG, 16'h001a);
    wr(`STPC_ADDR_CTRL, 16'h0001);
    #1;
    check({timer_out_o, timer_out_en_o}, '0);
    check({counter_run_enable_o}, 16'h0001);
    tally_and_finish();
  end
endmodule : timer_single_pulse_capture_test
